// [hdl/ppr_regs.svh]
// Register offsets, field layout and reset values of the peripheral pin router
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define PPR_NUM_INPUTS      20
`define PPR_NUM_PINS        18
`define PPR_NUM_SOURCES     28

// ----------------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------------
`define PPR_IN_ROUTE_BASE   12'h000
`define PPR_PIN_SRC_BASE    12'h080
`define PPR_LOCK_ADDR       12'h100

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define PPR_IN_ROUTE_W      6
`define PPR_PIN_SRC_W       5
`define PPR_LOCK_BIT        0

// ----------------------------------------------------------------------------
// Input pin codes: port A 0x00..0x05, port B 0x0c..0x0f, port C 0x10..0x17
// ----------------------------------------------------------------------------
`define PPR_PORTA_LAST      6'h05
`define PPR_PORTB_FIRST     6'h0c
`define PPR_PORTC_LAST      6'h17
`define PPR_HIGH_PIN_SHIFT  6'h06

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPR_LOCK_RESET      1'b0
`define PPR_PIN_SRC_RESET   5'h00
// Input defaults, entry 0 in the low bits: ext irq, timer0 clk, timer1 clk,
// timer1 gate, timer2 in, capture 1, capture 2, waveform in, logic in 0..3,
// adc trigger, serial clk, serial data, serial select, rx1, ck1, rx2, ck2
`define PPR_IN_DEFAULTS {6'h10, 6'h11, 6'h0f, 6'h0d, 6'h16, 6'h0c, 6'h0e, \
                         6'h12, 6'h0d, 6'h0c, 6'h13, 6'h02, 6'h02, 6'h13, \
                         6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02}

`endif

// [hdl/ppr_pkg.sv]
// Types shared by the peripheral pin router
package ppr_pkg;

   typedef logic [5:0] ppr_in_sel_t;
   typedef logic [4:0] ppr_out_sel_t;

   // Pin output source codes; any other code leaves the port latch on the pin
   typedef enum logic [4:0] {
      PPR_SRC_LATCH      = 5'h00,
      PPR_SRC_LOGIC1     = 5'h01,
      PPR_SRC_LOGIC2     = 5'h02,
      PPR_SRC_LOGIC3     = 5'h03,
      PPR_SRC_LOGIC4     = 5'h04,
      PPR_SRC_WAVE_A     = 5'h05,
      PPR_SRC_WAVE_B     = 5'h06,
      PPR_SRC_WAVE_C     = 5'h07,
      PPR_SRC_WAVE_D     = 5'h08,
      PPR_SRC_CAPCMP1    = 5'h09,
      PPR_SRC_CAPCMP2    = 5'h0a,
      PPR_SRC_PULSE3     = 5'h0b,
      PPR_SRC_PULSE4     = 5'h0c,
      PPR_SRC_PULSE5     = 5'h0d,
      PPR_SRC_PULSE6     = 5'h0e,
      PPR_SRC_USART1_TX  = 5'h0f,
      PPR_SRC_USART1_DT  = 5'h10,
      PPR_SRC_USART2_TX  = 5'h11,
      PPR_SRC_USART2_DT  = 5'h12,
      PPR_SRC_COMP1      = 5'h13,
      PPR_SRC_COMP2      = 5'h14,
      PPR_SRC_SER_CLK    = 5'h15,
      PPR_SRC_SER_DATA   = 5'h16,
      PPR_SRC_TIMER0     = 5'h19,
      PPR_SRC_NUM_OSC    = 5'h1a,
      PPR_SRC_REF_CLK    = 5'h1b
   } ppr_out_src_t;

endpackage

// [hdl/ppr_out_mux.sv]
// Output source selector for one device pin
`timescale 1ns/1ps

module ppr_out_mux
(
   input  wire logic                 [4:0]  src_sel,     // Pin output source code
   input  wire logic                 [27:0] periph_out,  // Peripheral outputs, bit n = code n
   input  wire logic                        port_latch,  // Ordinary port output latch
   output logic                             pin_out,     // Value driven to the pin
   output logic                             periph_own   // High while a peripheral drives
);

   // ----------------------------------------------------------------------------
   // Source decode
   // ----------------------------------------------------------------------------

   // Gaps at 0x17/0x18 and codes above 0x1b belong to nobody
   always_comb
   begin
      periph_own = ((src_sel >= ppr_pkg::PPR_SRC_LOGIC1) && (src_sel <= ppr_pkg::PPR_SRC_SER_DATA)) ||
                   ((src_sel >= ppr_pkg::PPR_SRC_TIMER0) && (src_sel <= ppr_pkg::PPR_SRC_REF_CLK));
   end

   // Unassigned codes fall back to the latch so a stray code never floats a pin
   always_comb
   begin
      if (periph_own)
         pin_out = periph_out[src_sel];
      else
         pin_out = port_latch;
   end

endmodule

// [hdl/ppr_router.sv]
// Peripheral pin router: input routes, pin output sources, lock, AHB-Lite slave
`timescale 1ns/1ps
`include "ppr_regs.svh"

module ppr_router
#(
   parameter int N_IN  = `PPR_NUM_INPUTS,  // Routable peripheral inputs
   parameter int N_PIN = `PPR_NUM_PINS     // Device pins
)
(
   input  wire logic                 hclk,              // System clock
   input  wire logic                 hresetn,           // Power-on reset, active low
   input  wire logic                 dev_reset,         // Any other device reset, high pulse
   input  wire logic                 one_shot_lock_cfg, // Lock may be set only once per reset
   input  wire logic                 hsel,              // Slave select
   input  wire logic [31:0]          haddr,             // Byte address
   input  wire logic [1:0]           htrans,            // Transfer type
   input  wire logic                 hwrite,            // Write when high
   input  wire logic [2:0]           hsize,             // Transfer size
   input  wire logic [31:0]          hwdata,            // Write data
   input  wire logic                 hready,            // Bus ready in
   output logic                      hreadyout,         // Always ready
   output logic [31:0]               hrdata,            // Read data, registered
   output logic                      hresp,             // Always OKAY
   input  wire logic [N_PIN-1:0]     pin_in,            // Pin input levels
   input  wire logic [N_PIN-1:0]     port_latch,        // Port output latches
   input  wire logic [27:0]          periph_out,        // Peripheral outputs, bit n = code n
   output logic      [N_IN-1:0]      periph_in,         // Routed peripheral inputs
   output logic      [N_PIN-1:0]     pin_out,           // Pin output values
   output logic      [N_PIN-1:0]     pin_periph_own,    // Pin driven by a peripheral
   output logic                      route_lock_bit     // Lock state
);

   // ----------------------------------------------------------------------------
   // Constants and helpers
   // ----------------------------------------------------------------------------

   localparam logic [N_IN*6-1:0] IN_DEFAULTS = `PPR_IN_DEFAULTS;
   localparam logic [11:0]       IN_BASE     = `PPR_IN_ROUTE_BASE;
   localparam logic [11:0]       PIN_BASE    = `PPR_PIN_SRC_BASE;
   localparam logic [11:0]       LOCK_ADDR   = `PPR_LOCK_ADDR;
   localparam logic [9:0]        N_IN_W      = 10'(N_IN);
   localparam logic [9:0]        N_PIN_W     = 10'(N_PIN);

   // True when the address lands on one word of an n-entry register array
   function automatic logic in_array(input logic [31:0] addr, input logic [11:0] base,
                                     input logic [9:0] n);
      logic [11:0] off;
      off = addr[11:0] - base;
      return (addr[31:12] == 20'h00000) && (addr[11:0] >= base) &&
             (off[1:0] == 2'b00) && (off[11:2] < n);
   endfunction

   // Word index within the array that starts at base
   function automatic logic [4:0] array_idx(input logic [31:0] addr, input logic [11:0] base);
      logic [11:0] off;
      off = addr[11:0] - base;
      return off[6:2];
   endfunction

   // Pin code to pin position: ports B and C sit six codes above their position
   function automatic logic [4:0] pin_pos(input ppr_pkg::ppr_in_sel_t code);
      logic [5:0] pos;
      pos = (code <= `PPR_PORTA_LAST) ? code : (code - `PPR_HIGH_PIN_SHIFT);
      return pos[4:0];
   endfunction

   // Pin code names a pin of this device
   function automatic logic pin_valid(input ppr_pkg::ppr_in_sel_t code);
      return (code <= `PPR_PORTA_LAST) ||
             ((code >= `PPR_PORTB_FIRST) && (code <= `PPR_PORTC_LAST));
   endfunction

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------

   ppr_pkg::ppr_in_sel_t   in_route_reg [N_IN];
   ppr_pkg::ppr_out_sel_t  pin_src_reg  [N_PIN];
   logic                   lock_reg;
   logic                   lock_spent_reg;
   logic                   wr_pend_reg;
   logic [31:0]            addr_reg;
   logic [31:0]            rdata_reg;
   logic [31:0]            rdata_next;
   logic                   addr_phase;
   logic                   sel_wr_ok;
   logic                   lock_wr_ok;
   logic                   lock_wr_hit;

   // ----------------------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------------------

   // Zero-wait slave; every access answers OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;
   assign addr_phase = hsel && hready && htrans[1];

   // Hold write address until its data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 32'h00000000;
      end
      else if (hready)
      begin
         wr_pend_reg <= addr_phase && hwrite;
         addr_reg    <= haddr;
      end
   end

   // Read value picked in the address phase; unmapped words read zero
   always_comb
   begin
      rdata_next = 32'h00000000;
      if (in_array(haddr, IN_BASE, N_IN_W))
         rdata_next = {26'h0000000, in_route_reg[array_idx(haddr, IN_BASE)]};
      else if (in_array(haddr, PIN_BASE, N_PIN_W))
         rdata_next = {27'h0000000, pin_src_reg[array_idx(haddr, PIN_BASE)]};
      else if (haddr == {20'h00000, LOCK_ADDR})
         rdata_next = {31'h00000000, lock_reg};
   end

   // Read data launched so it stands through the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdata_reg <= 32'h00000000;
      else if (addr_phase && !hwrite)
         rdata_reg <= rdata_next;
   end

   // ----------------------------------------------------------------------------
   // Lock control
   // ----------------------------------------------------------------------------

   // Selections move only while unlocked
   assign sel_wr_ok   = wr_pend_reg && !lock_reg;
   assign lock_wr_hit = wr_pend_reg && (addr_reg == {20'h00000, LOCK_ADDR});
   // One-shot mode freezes the lock once it has been set after a reset
   assign lock_wr_ok  = lock_wr_hit && !(one_shot_lock_cfg && lock_spent_reg);

   // Lock and its one-shot history clear on every reset, power-on included
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lock_reg       <= `PPR_LOCK_RESET;
         lock_spent_reg <= 1'b0;
      end
      else if (dev_reset)
      begin
         lock_reg       <= `PPR_LOCK_RESET;
         lock_spent_reg <= 1'b0;
      end
      else if (lock_wr_ok)
      begin
         lock_reg <= hwdata[`PPR_LOCK_BIT];
         if (hwdata[`PPR_LOCK_BIT] && one_shot_lock_cfg)
            lock_spent_reg <= 1'b1;
      end
   end

   assign route_lock_bit = lock_reg;

   // ----------------------------------------------------------------------------
   // Input route registers
   // ----------------------------------------------------------------------------

   // Only power-on reset reloads; other resets and sleep have no path here
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < N_IN; i++)
            in_route_reg[i] <= IN_DEFAULTS[i*6 +: 6];
      end
      else if (sel_wr_ok && in_array(addr_reg, IN_BASE, N_IN_W))
      begin
         for (int i = 0; i < N_IN; i++)
            if (array_idx(addr_reg, IN_BASE) == 5'(i))
               in_route_reg[i] <= hwdata[`PPR_IN_ROUTE_W-1:0];
      end
   end

   // Unsupported codes give a quiet zero rather than an arbitrary pin
   always_comb
   begin
      for (int i = 0; i < N_IN; i++)
      begin
         if (pin_valid(in_route_reg[i]))
            periph_in[i] = pin_in[pin_pos(in_route_reg[i])];
         else
            periph_in[i] = 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Pin output source registers
   // ----------------------------------------------------------------------------

   // Same reset split as the input routes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int j = 0; j < N_PIN; j++)
            pin_src_reg[j] <= `PPR_PIN_SRC_RESET;
      end
      else if (sel_wr_ok && in_array(addr_reg, PIN_BASE, N_PIN_W))
      begin
         for (int j = 0; j < N_PIN; j++)
            if (array_idx(addr_reg, PIN_BASE) == 5'(j))
               pin_src_reg[j] <= hwdata[`PPR_PIN_SRC_W-1:0];
      end
   end

   // One selector per pin
   for (genvar j = 0; j < N_PIN; j++)
   begin : g_pin
      ppr_out_mux u_mux
      (
         .src_sel    (pin_src_reg[j]),
         .periph_out (periph_out),
         .port_latch (port_latch[j]),
         .pin_out    (pin_out[j]),
         .periph_own (pin_periph_own[j])
      );
   end

endmodule

// [sim/ppr_router_properties.sv]
// Port checker for the peripheral pin router, with its bind
`timescale 1ns/1ps

// ----------------------------
// Checker
// ----------------------------
module ppr_router_chk
#(
   parameter int N_IN  = 20, // Routed inputs
   parameter int N_PIN = 18  // Pins
)
(
   input wire logic             hclk,           // Clock
   input wire logic             hresetn,        // Power-on reset
   input wire logic             dev_reset,      // Other reset
   input wire logic             hsel,           // Select
   input wire logic [31:0]      haddr,          // Address
   input wire logic [1:0]       htrans,         // Type
   input wire logic             hwrite,         // Write
   input wire logic             hready,         // Ready in
   input wire logic [31:0]      hrdata,         // Read data
   input wire logic             hreadyout,      // Ready out
   input wire logic             hresp,          // Response
   input wire logic [N_PIN-1:0] pin_in,         // Pin levels
   input wire logic [N_PIN-1:0] port_latch,     // Latches
   input wire logic [27:0]      periph_out,     // Peripheral outs
   input wire logic [N_IN-1:0]  periph_in,      // Routed inputs
   input wire logic [N_PIN-1:0] pin_out,        // Pin values
   input wire logic [N_PIN-1:0] pin_periph_own, // Owned pins
   input wire logic             route_lock_bit  // Lock
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Write data phases; a store lands at the edge that ends one
   logic wph_reg;
   logic lkph_reg;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wph_reg  <= 1'b0;
         lkph_reg <= 1'b0;
      end
      else if (hready)
      begin
         wph_reg  <= hsel && htrans[1] && hwrite;
         lkph_reg <= hsel && htrans[1] && hwrite && haddr == 32'h0000_0100;
      end

   chk_rdata_upper: assert property (hrdata[31:6] == 26'h0)
      else $error("read data upper bits set");
   chk_resp_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_latch_free: assert property ((pin_out & ~pin_periph_own) == (port_latch & ~pin_periph_own))
      else $error("free pin not on its latch");
   chk_lock_rise: assert property ($rose(route_lock_bit) |-> $past(lkph_reg))
      else $error("lock set without a lock write");
   chk_devrst_lock: assert property (dev_reset |=> !route_lock_bit)
      else $error("lock kept over device reset");
   chk_devrst_keep: assert property (dev_reset && !wph_reg |=> $stable(pin_periph_own))
      else $error("selection lost on device reset");
   chk_lock_freeze: assert property (route_lock_bit |=> $stable(pin_periph_own))
      else $error("selection changed while locked");
   chk_route_stable: assert property ($stable(pin_in) && !$past(wph_reg) |-> $stable(periph_in))
      else $error("input route moved by itself");
   chk_out_stable: assert property ($stable(port_latch) && $stable(periph_out) && !$past(wph_reg)
      |-> $stable(pin_out))
      else $error("pin output moved by itself");
   chk_reset_dflt: assert property ($rose(hresetn) |-> pin_periph_own == '0 && !route_lock_bit)
      else $error("no default after power-on reset");
endmodule

bind ppr_router ppr_router_chk #(.N_IN(N_IN), .N_PIN(N_PIN)) chk_u
(
   .hclk(hclk), .hresetn(hresetn), .dev_reset(dev_reset), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .pin_in(pin_in),
   .port_latch(port_latch), .periph_out(periph_out), .periph_in(periph_in), .pin_out(pin_out),
   .pin_periph_own(pin_periph_own), .route_lock_bit(route_lock_bit)
);

// [sim/ppr_io_model.sv]
// Model of the pins and peripherals around the router
`timescale 1ns/1ps

module ppr_io_model
(
   input  wire logic [31:0] pat,       // Outside stimulus
   input  wire logic [17:0] pin_out,   // Router pin values
   input  wire logic [17:0] pin_own,   // Peripheral-driven pins
   output logic      [17:0] pin_in,    // Pin levels
   output logic      [17:0] port_latch,// Port latches
   output logic      [27:0] periph_out // Peripheral outputs
);
   // Driven pins read back their own level, free pins the outside one
   assign pin_in     = (pin_out & pin_own) | (pat[17:0] & ~pin_own);
   assign port_latch = ~pat[17:0];
   assign periph_out = pat[27:0];
endmodule

// [sim/ppr_router_bench.sv]
// Self-checking bench of the peripheral pin router
`timescale 1ns/1ps
`include "ppr_regs.svh"

module ppr_router_bench;
   localparam logic [119:0] DFLT = `PPR_IN_DEFAULTS;
   logic        hclk, hresetn, dev_reset, cfg, hsel, hwrite, vk, a, hresp, route_lock_bit;
   logic [31:0] haddr, hwdata, hrdata, r, pat, obs, e, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize, kd;
   logic        hreadyout;
   logic [17:0] pin_in, port_latch, pin_out, own;
   logic [27:0] periph_out;
   logic [19:0] periph_in;
   logic [31:0] q[$];
   string       nm[4] = '{"hrdata", "pin_out", "periph_in", "pin_periph_own"};
   int          mismatches, tests_run, i, p;
   int          pp[20];

   ppr_router dut_u
   (
      .hclk(hclk), .hresetn(hresetn), .dev_reset(dev_reset), .one_shot_lock_cfg(cfg),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .pin_in(pin_in), .port_latch(port_latch), .periph_out(periph_out), .periph_in(periph_in),
      .pin_out(pin_out), .pin_periph_own(own), .route_lock_bit(route_lock_bit)
   );
   ppr_io_model io_u
   (
      .pat(pat), .pin_out(pin_out), .pin_own(own), .pin_in(pin_in), .port_latch(port_latch),
      .periph_out(periph_out)
   );

   // ----------------------------
   // Helpers
   // ----------------------------
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] cd(input int n);
      return (n < 6) ? n : n + 6;
   endfunction

   // One single transfer; a trailing idle keeps read-after-write clean
   task xf(input logic w, input logic [31:0] ad, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= ad;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      kd     <= 3'd0;
      vk     <= !w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      vk <= 1'b0;
      @(posedge hclk);
   endtask
   task rd(input logic [31:0] ad, input logic [31:0] ex);
      q.push_back(ex);
      xf(1'b0, ad, 32'h0);
   endtask
   task pk(input logic [2:0] k, input logic [31:0] ex);
      q.push_back(ex);
      kd <= k;
      vk <= 1'b1;
      @(posedge hclk);
      vk <= 1'b0;
      @(posedge hclk);
   endtask
   task report_and_stop;
      $display("TB: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Result watcher: oldest note against what the outputs show
   always @(posedge hclk)
      if (vk && hreadyout)
      begin
         obs = kd == 0 ? hrdata : kd == 1 ? {14'h0, pin_out} : kd == 2 ? {12'h0, periph_in} : {14'h0, own};
         e = q.pop_front();
         tests_run++;
         if (obs !== e)
         begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm[kd], e, obs);
         end
      end

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // Hang guard, far beyond the run's length
   initial
   begin
      repeat (5000) @(posedge hclk);
      mismatches++;
      report_and_stop;
   end

   // ----------------------------
   // Scenarios
   // ----------------------------
   initial
   begin
      {hresetn, dev_reset, cfg, hsel, hwrite, vk} = '0;
      {haddr, hwdata, pat} = '0;
      htrans = 2'b00;
      hsize = 3'b010;
      kd = 3'd0;
      r = 32'h822f0db1;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // Defaults, then an unmapped word
      for (i = 0; i < 20; i++) rd(4 * i, 32'(DFLT[6 * i +: 6]));
      for (i = 0; i < 18; i++) rd(32'h80 + 4 * i, 32'h0);
      rd(32'h100, 32'h0);
      rd(32'h104, 32'h0);
      // Random legal pin per input, pins may repeat, all written before any read back
      for (i = 0; i < 20; i++)
      begin
         r = nx(r);
         p = (i == 0) ? r[3:0] % 10 : r[4:0] % 18;
         pp[i] = p;
         xf(1'b1, 4 * i, {r[31:6], 6'(cd(p))});
      end
      for (i = 0; i < 20; i++) rd(4 * i, cd(pp[i]));
      for (i = 0; i < 3; i++)
      begin
         r = nx(r);
         pat <= r;
         for (p = 0; p < 20; p++) v[p] = r[pp[p]];
         pk(3'd2, {12'h0, v[19:0]});
      end
      // Every source code on one pin, the rest stay on their latches
      for (i = 0; i < 32; i++)
      begin
         r = nx(r);
         pat <= r;
         xf(1'b1, 32'h8c, {r[31:5], 5'(i)});
         rd(32'h8c, 32'(i));
         a = (i > 0 && i < 32'h17) || (i > 32'h18 && i < 32'h1c);
         v = {14'h0, ~r[17:0]};
         v[3] = a ? r[i] : ~r[3];
         pk(3'd1, v);
         pk(3'd3, {28'h0, a, 3'b000});
      end
      // Lock refuses writes until cleared
      xf(1'b1, 32'h100, 32'h1);
      xf(1'b1, 32'h0, 32'h3f);
      xf(1'b1, 32'h8c, 32'h1b);
      rd(32'h0, cd(pp[0]));
      rd(32'h8c, 32'h1f);
      xf(1'b1, 32'h100, 32'h0);
      xf(1'b1, 32'h8c, 32'h1b);
      rd(32'h8c, 32'h1b);
      // One-shot lock, then a device reset
      cfg <= 1'b1;
      xf(1'b1, 32'h100, 32'h1);
      xf(1'b1, 32'h100, 32'h0);
      rd(32'h100, 32'h1);
      dev_reset <= 1'b1;
      @(posedge hclk);
      dev_reset <= 1'b0;
      rd(32'h100, 32'h0);
      rd(32'h8c, 32'h1b);
      rd(32'h0, cd(pp[0]));
      xf(1'b1, 32'h100, 32'h1);
      // Power-on reset in mid-run
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(32'h8c, 32'h0);
      rd(32'h0, 32'(DFLT[5:0]));
      rd(32'h100, 32'h0);
      xf(1'b1, 32'h0, 32'h11);
      rd(32'h0, 32'h11);
      report_and_stop;
   end
endmodule
